// ### src/mm_map.svh
`ifndef MM_MAP_SVH
`define MM_MAP_SVH

// register placement on the apb window (byte addresses)
`define MAP_FIRST_OFF 12'h200
`define MAP_LAST_OFF 12'h3c0
// one mapping register per 64-byte slot, node = slot index low bits
`define MAP_SLOT_SHIFT 6
`define MAP_SLOT_MASK 12'h03f
// decode status register, read only
`define STAT_OFF 12'h400

// mapping register layout
`define MAP_WR_MASK 32'hfffe07ff
`define MAP_RST_VAL 32'h00000000
`define RSVD_HI 16
`define RSVD_LO 11
`define BASE_W 15
`define CMD_ADDR_W 40

// low memory address bit used for interleave compare
`define INTLV_BIT_DEF 6

// apb answer timing: wait cycles before pready
`define APB_WAIT_CYC 1

`endif

// ### src/mm_pkg.sv
package mm_pkg;

	// interleave factor codes
	typedef enum logic [1:0] {
		INTLV_1,
		INTLV_2,
		INTLV_4,
		INTLV_RSV
	} intlv_code_t;

	// one node mapping word
	typedef struct packed {
		logic [14:0] base;       // base address msbs
		logic [5:0] rsvd;        // always zero
		logic [1:0] bank_count_code;
		logic [3:0] base_valid_width;
		logic [1:0] interleave_position;
		intlv_code_t intlv;      // modules interleaved
		logic en;                // node present
	} map_word_t;

endpackage

// ### src/map_cfg_if.sv
`timescale 1ns/100ps
`include "mm_map.svh"

interface map_cfg_if;
	import mm_pkg::*;
	map_word_t cfg;                    // node mapping word
	logic [`CMD_ADDR_W-1:0] addr;      // command byte address
	logic hit;                         // address owned by node
	logic [2:0] bank;                  // bank number bits

	// register bank side
	modport cfg_src (output cfg, output addr, input hit, input bank);
	// matcher side
	modport matcher (input cfg, input addr, output hit, output bank);
endinterface

// ### src/node_match.sv
`timescale 1ns/100ps
`include "mm_map.svh"

module node_match import mm_pkg::*; #(
	parameter int INTLV_BIT = `INTLV_BIT_DEF
) (
	// mapping word and address in, hit out
	map_cfg_if.matcher m
);

	logic [`BASE_W-1:0] valid_mask;  // base bits that take part
	logic [`BASE_W-1:0] addr_base;   // address bits 39:25
	logic [1:0] nint;                // interleave bits used
	logic intlv_ok;                  // interleave position agrees
	logic [2:0] bank_mask;           // bank bits in use
	logic [`CMD_ADDR_W-1:0] shifted; // address past interleave bits

	assign addr_base = m.addr[`CMD_ADDR_W-1 -: `BASE_W];

	// width field keeps the top bits of the base only
	genvar i;
	generate
		for (i = 0; i < `BASE_W; i++) begin : g_vmask
			assign valid_mask[i] = (5'(i) + {1'b0, m.cfg.base_valid_width})
				>= 5'(`BASE_W);
		end
	endgenerate

	// interleave compare against low memory address bits
	always_comb begin
		nint = 2'd0;
		intlv_ok = 1'b0;
		case (m.cfg.intlv)
			INTLV_1: begin
				intlv_ok = 1'b1;
			end
			INTLV_2: begin
				nint = 2'd1;
				intlv_ok = m.cfg.interleave_position[0] == m.addr[INTLV_BIT];
			end
			INTLV_4: begin
				nint = 2'd2;
				intlv_ok = m.cfg.interleave_position ==
					m.addr[INTLV_BIT +: 2];
			end
			default: begin
				intlv_ok = 1'b0; // reserved code owns nothing
			end
		endcase
	end

	// bank number from bits just above the interleave bits
	assign shifted = m.addr >> (INTLV_BIT + int'(nint));
	assign bank_mask = 3'((4'h1 << m.cfg.bank_count_code) - 4'h1);
	assign m.bank = shifted[2:0] & bank_mask;

	// node owns the address
	assign m.hit = m.cfg.en & intlv_ok &
		(((addr_base ^ m.cfg.base) & valid_mask) == '0);

endmodule // node_match

// ### src/memory_map_config_regs.sv
`timescale 1ns/100ps
`include "mm_map.svh"

module memory_map_config_regs import mm_pkg::*; #(
	parameter int NODES = 8,
	parameter int ADDR_W = 12,
	parameter int INTLV_BIT = `INTLV_BIT_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command address from the system bus
	input wire logic cmd_valid,
	input wire logic [`CMD_ADDR_W-1:0] cmd_addr,
	// decode result, one cycle later
	output logic [NODES-1:0] node_hit,
	output logic [2:0] node_bank,
	output logic hit_valid,
	output logic multi_hit
);

	// apb handshake strobes
	logic take;      // access phase first cycle, answer prepared
	logic done;      // transfer completes at this edge

	// address decode
	logic map_sel;   // address is one of the mapping words
	logic stat_sel;  // address is the status word
	logic [2:0] idx; // node index of the mapping word

	// storage
	map_word_t map_reg [NODES];  // one word per node
	logic [31:0] wr_next;        // merged write value
	logic [31:0] rd_next;        // read mux output

	// answer flops
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	// decode result flops
	logic [NODES-1:0] node_hit_reg;
	logic [2:0] node_bank_reg;
	logic hit_valid_reg;
	logic multi_hit_reg;
	logic [NODES-1:0] last_hit_reg;  // held for status reads
	logic [2:0] last_bank_reg;
	logic last_multi_reg;

	// per node results
	logic [NODES-1:0] hit_vec;
	logic [2:0] bank_vec [NODES];
	logic [NODES-1:0] en_vec;   // enable bits
	logic [NODES-1:0] rsv_vec;  // reserved interleave code
	logic [2:0] bank_next;
	logic [3:0] hit_count;

	// apb wait state generator
	apb_port #(
		.WAIT_CYC(`APB_WAIT_CYC)
	) u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pready(pready),
		.take(take),
		.done(done)
	);

	// address decode chain
	always_comb begin
		map_sel = 1'b0;
		stat_sel = 1'b0;
		if (paddr >= ADDR_W'(`MAP_FIRST_OFF) &&
			paddr <= ADDR_W'(`MAP_LAST_OFF) &&
			(paddr & ADDR_W'(`MAP_SLOT_MASK)) == '0) begin
			map_sel = 1'b1;
		end else if (paddr == ADDR_W'(`STAT_OFF)) begin
			stat_sel = 1'b1;
		end
	end

	// node index is the slot number low bits
	assign idx = paddr[`MAP_SLOT_SHIFT +: 3];

	// byte lane merge, reserved bits forced to zero
	always_comb begin
		wr_next = map_reg[idx];
		for (int b = 0; b < 4; b++) begin
			if (pstrb[b]) begin
				wr_next[8*b +: 8] = pwdata[8*b +: 8];
			end
		end
		wr_next = wr_next & `MAP_WR_MASK;
	end

	// read mux
	always_comb begin
		rd_next = 32'h00000000;
		if (map_sel) begin
			rd_next = map_reg[idx] & `MAP_WR_MASK;
		end else if (stat_sel) begin
			rd_next[NODES-1:0] = last_hit_reg;
			rd_next[10:8] = last_bank_reg;
			rd_next[11] = |last_hit_reg;
			rd_next[12] = last_multi_reg;
		end
	end

	// mapping register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int n = 0; n < NODES; n++) begin
				map_reg[n] <= `MAP_RST_VAL;
			end
		end else if (done && pwrite && map_sel) begin
			map_reg[idx] <= wr_next;
		end
	end

	// read data, latched as the answer is prepared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (take) begin
			prdata_reg <= pwrite ? 32'h00000000 : rd_next;
		end
	end

	// error answer for unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (take) begin
			pslverr_reg <= !map_sel && !stat_sel;
		end else if (done) begin
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// one matcher per node
	genvar g;
	generate
		for (g = 0; g < NODES; g++) begin : g_node
			map_cfg_if mif ();
			assign mif.cfg = map_reg[g];
			assign mif.addr = cmd_addr;
			assign hit_vec[g] = mif.hit;
			assign bank_vec[g] = mif.bank;
			assign en_vec[g] = map_reg[g].en;
			assign rsv_vec[g] = map_reg[g].intlv == INTLV_RSV;
			node_match #(
				.INTLV_BIT(INTLV_BIT)
			) u_match (
				.m(mif.matcher)
			);
		end
	endgenerate

	// lowest hitting node supplies the bank number
	always_comb begin
		bank_next = 3'h0;
		hit_count = 4'h0;
		for (int n = NODES - 1; n >= 0; n--) begin
			if (hit_vec[n]) begin
				bank_next = bank_vec[n];
			end
		end
		for (int n = 0; n < NODES; n++) begin
			hit_count = hit_count + {3'h0, hit_vec[n]};
		end
	end

	// decode result, one pulse per command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_hit_reg <= '0;
			node_bank_reg <= 3'h0;
			hit_valid_reg <= 1'b0;
			multi_hit_reg <= 1'b0;
		end else if (cmd_valid) begin
			node_hit_reg <= hit_vec;
			node_bank_reg <= bank_next;
			hit_valid_reg <= |hit_vec;
			multi_hit_reg <= hit_count > 4'h1;
		end else begin
			node_hit_reg <= '0;
			node_bank_reg <= 3'h0;
			hit_valid_reg <= 1'b0;
			multi_hit_reg <= 1'b0;
		end
	end

	// last decode kept for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_hit_reg <= '0;
			last_bank_reg <= 3'h0;
			last_multi_reg <= 1'b0;
		end else if (cmd_valid) begin
			last_hit_reg <= hit_vec;
			last_bank_reg <= bank_next;
			last_multi_reg <= hit_count > 4'h1;
		end
	end

	assign node_hit = node_hit_reg;
	assign node_bank = node_bank_reg;
	assign hit_valid = hit_valid_reg;
	assign multi_hit = multi_hit_reg;

	// checks on register access and address decode
	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence apb_access_s;
		psel && penable;
	endsequence

	sequence map_read_s;
		take && !pwrite && map_sel;
	endsequence

	// pready comes exactly one cycle into the access phase
	apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_setup_s ##1 apb_access_s |-> !pready ##1 pready)
		else $error("pready not one cycle into access");

	// read of slot k returns node k word
	node_index_a: assert property (@(posedge pclk) disable iff (!presetn)
		map_read_s |=> (prdata == ($past(map_reg[idx]) & `MAP_WR_MASK))
			&& pready)
		else $error("mapping read returned wrong word");

	// reserved bits never read as one
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && psel && penable && !pwrite && map_sel) |->
			prdata[`RSVD_HI:`RSVD_LO] == 6'h00)
		else $error("reserved bits read nonzero");

	// written base lands in the addressed word
	write_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && map_sel && pstrb == 4'hf) |=>
			map_reg[$past(idx)] == ($past(pwdata) & `MAP_WR_MASK))
		else $error("mapping write not stored");

	// unmapped address answers with error
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(take && !map_sel && !stat_sel) |=> pready && pslverr)
		else $error("unmapped access without error");

	// disabled nodes never hit
	enable_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_valid |=> (node_hit & ~$past(en_vec)) == '0)
		else $error("disabled node reported a hit");

	// reserved interleave code owns nothing
	intlv_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_valid |=> (node_hit & $past(rsv_vec)) == '0)
		else $error("reserved interleave code hit");

	// full width base match on node zero hits
	base_match_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_valid && map_reg[0].en && map_reg[0].base_valid_width == 4'hf
			&& map_reg[0].intlv == INTLV_1
			&& cmd_addr[`CMD_ADDR_W-1 -: `BASE_W] == map_reg[0].base)
			|=> node_hit[0] && hit_valid)
		else $error("matching base did not hit node zero");

	// bank number limited by bank count
	bank_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_valid && hit_vec == 8'h01) |=>
			(node_bank >> $past(map_reg[0].bank_count_code)) == 3'h0)
		else $error("bank number exceeds bank count");

	// pready stands for one cycle only
	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held for two cycles");

	// error answer only comes with pready
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");

	// decode outputs clear when no command came
	hit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cmd_valid |=> node_hit == '0 && !hit_valid && !multi_hit)
		else $error("decode outputs stood without a command");

	// multi hit flag needs several hitting nodes
	multi_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		multi_hit |-> hit_valid && !$onehot(node_hit))
		else $error("multi hit flag without several hits");

	// any hit flag agrees with the hit vector
	any_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		hit_valid == (|node_hit))
		else $error("hit valid disagrees with hit vector");

	// position bit unlike the address keeps node zero out
	intlv_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_valid && map_reg[0].intlv == INTLV_2 &&
			map_reg[0].interleave_position[0] != cmd_addr[INTLV_BIT])
			|=> !node_hit[0])
		else $error("interleave position mismatch still hit");

	sequence stat_read_s;
		take && !pwrite && stat_sel;
	endsequence

	// status read returns the last decode
	stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		stat_read_s |=> prdata[NODES-1:0] == $past(last_hit_reg)
			&& prdata[12] == $past(last_multi_reg))
		else $error("status read returned wrong decode");

	// bytes left out of the strobes keep their old value
	lane_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && map_sel && pstrb == 4'h2) |=>
			map_reg[$past(idx)][31:16] == $past(map_reg[idx][31:16])
			&& map_reg[$past(idx)][7:0] == $past(map_reg[idx][7:0]))
		else $error("unstrobed byte of mapping word changed");

	// reserved bits are never stored
	rsvd_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && map_sel) |=>
			map_reg[$past(idx)].rsvd == 6'h00)
		else $error("reserved bits stored as one");

endmodule // memory_map_config_regs

// ### src/apb_port.sv
`timescale 1ns/100ps

module apb_port #(
	parameter int WAIT_CYC = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb phase signals
	input wire logic psel,
	input wire logic penable,
	// answer and strobes
	output logic pready,
	output logic take,
	output logic done
);

	logic pready_reg;  // high in the cycle the transfer completes

	// pready rises one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else if (psel && penable && !pready_reg) begin
			pready_reg <= WAIT_CYC > 0;
		end else begin
			pready_reg <= 1'b0;
		end
	end

	assign pready = pready_reg;
	assign take = psel && penable && !pready_reg;
	assign done = psel && penable && pready_reg;

endmodule // apb_port

// ### test/amr_model.sv
`timescale 1ns/100ps

// copy source: map word held by each memory module
module map_copy_source #(
	parameter logic [31:0] SEED = 32'h5a5a0f0f
) (
	// node select
	input wire logic [2:0] node,
	// that module's map word
	output logic [31:0] map_word
);
	// words differ per node; reserved bits may be set here
	assign map_word = SEED ^ {4{node, 5'h13}};
endmodule // map_copy_source

// ### test/testbench.sv
`timescale 1ns/100ps
`include "mm_map.svh"
`define CHK(g, e) check_eq(32'(g), 32'(e))

module testbench import mm_pkg::*;;
	// apb and command signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic cmd_valid, hit_valid, multi_hit, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lfsr_reg, r, w;
	logic [3:0] pstrb;
	logic [39:0] cmd_addr, a;
	logic [7:0] node_hit;
	logic [2:0] node_bank, src_node;
	logic [31:0] words [8]; // bench copy of each node word
	logic [31:0] map_word;
	logic [12:0] e;
	int n_fail, tests_run;

	memory_map_config_regs u_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
		.node_hit(node_hit), .node_bank(node_bank),
		.hit_valid(hit_valid), .multi_hit(multi_hit));
	map_copy_source u_src (.node(src_node), .map_word(map_word));

	// free running clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// lfsr stepping
	function automatic logic [31:0] rnd();
		lfsr_reg = {lfsr_reg[30:0], ^(lfsr_reg & 32'h80200003)};
		return lfsr_reg;
	endfunction

	// byte address of a node word
	function automatic logic [11:0] map_addr(int n);
		return 12'(`MAP_FIRST_OFF + (n << `MAP_SLOT_SHIFT));
	endfunction

	// expected {multi, any, bank, hits} for one address
	function automatic logic [12:0] predict(logic [39:0] ad);
		logic [7:0] h;
		logic [2:0] b;
		logic [14:0] m;
		logic ok;
		int c;
		h = 8'h00;
		b = 3'h0;
		c = 0;
		for (int n = 7; n >= 0; n--) begin
			m = ~(15'h7fff >> words[n][8:5]);
			ok = (words[n][2:1] == 2'h0) ||
				(words[n][2:1] == 2'h1 && words[n][3] == ad[6]) ||
				(words[n][2:1] == 2'h2 && words[n][4:3] == ad[7:6]);
			// lowest index wins the bank
			if (words[n][0] && ((words[n][31:17] ^ ad[39:25]) & m) == 0
				&& ok) begin
				h[n] = 1'b1;
				c++;
				b = 3'(ad >> (`INTLV_BIT_DEF + words[n][2:1])) &
					3'(3'h7 >> (3 - words[n][10:9]));
			end
		end
		return {c > 1, c > 0, b, h};
	endfunction

	// compare and count
	task check_eq(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask

	// verdict and end of run
	task close_out();
		$display("checks %0d, failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one apb transfer, result in rd and err
	task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
		input logic [3:0] sb);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		pstrb <= sb;
		@(posedge pclk);
		penable <= 1'b1;
		// bounded wait for pready
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_fail++;
			close_out();
		end
	endtask

	// main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, cmd_valid} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		cmd_addr = 40'h0;
		src_node = 3'h0;
		lfsr_reg = 32'h269fdc0b;
		n_fail = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// all eight words clear, unmapped slot refused
		for (int n = 0; n < 8; n++) begin
			apb(1'b0, map_addr(n), 32'h0, 4'h0);
			`CHK(rd, 32'h0);
		end
		apb(1'b0, 12'h100, 32'h0, 4'h0);
		`CHK(err, 1'b1);
		$display("test reset done");
		// copy module words in, read each back
		for (int n = 0; n < 8; n++) begin
			src_node = 3'(n);
			#1;
			words[n] = map_word & `MAP_WR_MASK;
			apb(1'b1, map_addr(n), map_word, 4'hf);
		end
		apb(1'b1, map_addr(3), 32'hffffffff, 4'h2);
		words[3] = (words[3] | 32'h0000ff00) & `MAP_WR_MASK;
		// misaligned slot refused, status word ignores writes
		apb(1'b1, 12'h210, 32'hffffffff, 4'hf);
		`CHK(err, 1'b1);
		apb(1'b1, `STAT_OFF, 32'hffffffff, 4'hf);
		`CHK(err, 1'b0);
		for (int n = 0; n < 8; n++) begin
			apb(1'b0, map_addr(n), 32'h0, 4'h0);
			`CHK(rd, words[n]);
			`CHK(rd[31:17], words[n][31:17]);
			`CHK(rd[16:11], 6'h00);
		end
		$display("test copy done");
		// reset in mid run clears every word
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int n = 0; n < 8; n++) begin
			apb(1'b0, map_addr(n), 32'h0, 4'h0);
			`CHK(rd, 32'h0);
		end
		$display("test reset again done");
		// random maps, corner codes first
		for (int t = 0; t < 48; t++) begin
			r = rnd();
			a = {r[7:0], rnd()};
			for (int n = 0; n < 8; n++) begin
				w = rnd() & `MAP_WR_MASK;
				if (r[n + 8])
					w[31:17] = a[39:25];
				if (t < 16 && n == t % 8) begin
					w[31:17] = a[39:25];
					w[10:5] = {t[3:2], 4'hf};
					w[2:0] = {t[1:0], 1'b1};
				end
				words[n] = w;
				apb(1'b1, map_addr(n), w, 4'hf);
			end
			e = predict(a);
			@(posedge pclk);
			cmd_valid <= 1'b1;
			cmd_addr <= a;
			@(posedge pclk);
			cmd_valid <= 1'b0;
			@(negedge pclk);
			`CHK(node_hit, e[7:0]);
			`CHK({multi_hit, hit_valid}, e[12:11]);
			`CHK(node_bank, e[10:8]);
			@(negedge pclk);
			`CHK(node_hit, 8'h00);
			apb(1'b0, `STAT_OFF, 32'h0, 4'h0);
			`CHK(rd, {19'h0, e});
		end
		$display("test decode done");
		close_out();
	end
endmodule // testbench
